/* File: verilog/ccm_pkg.sv */
// package: constants and types for the controller mode state machine
`default_nettype none
package ccm_pkg;
  // controller states, one-hot codes
  typedef enum logic [3:0] {
    CCM_ST_UNINIT  = 4'b0001,
    CCM_ST_STOPPED = 4'b0010,
    CCM_ST_STARTED = 4'b0100,
    CCM_ST_SLEEP   = 4'b1000
  } ccm_state_t;

  // mode request codes
  typedef enum logic [1:0] {
    CCM_REQ_START = 2'h0,
    CCM_REQ_STOP  = 2'h1,
    CCM_REQ_SLEEP = 2'h2
  } ccm_mode_t;

  // host command bundle
  typedef struct packed {
    logic init_all;
    logic deinit;
    logic mode_req;
    ccm_mode_t mode;
    logic rate_req;
    logic rate_reinit;
  } ccm_cmd_t;

  // settle delay of a mode change, in ns, and its cycle count at 25 MHz
  localparam int unsigned CCM_CLK_PERIOD_NS = 40;
  localparam int unsigned CCM_SETTLE_NS = 400;
  localparam int unsigned CCM_SETTLE_CYC =
    (CCM_SETTLE_NS + CCM_CLK_PERIOD_NS - 1) / CCM_CLK_PERIOD_NS;

  // defaults
  localparam int unsigned CCM_NUM_CTRL = 2;
  localparam int unsigned CCM_CFG_W = 8;
  localparam logic [7:0] CCM_CFG_RESET = 8'h00;
  localparam logic [7:0] CCM_CFG_STATIC = 8'h1C;
  localparam logic [3:0] CCM_CNT_ZERO = 4'h0;
endpackage : ccm_pkg
`default_nettype wire

/* File: verilog/ccm_mode_fsm.sv */
// module: per-controller mode state machine for a multi-controller unit
//
// Summary of operation
// - init-all loads config, all controllers stopped
// - init-all when not uninitialised flags illegal transition
// - rate change keeps current controller state
// - reinit rate change outside stopped refused
// - reinit change keeps stopped, bus disabled
// - mode changes settle; done flag polled
// - start moves stopped to started
// - start outside stopped flags invalid transition
// - stop from started/sleep reaches stopped
// - stop cancels pending transmit requests
// - no hw sleep: stop only clears sleep
// - hw sleep: enter sleep, arm wake
// - no hw sleep: logical sleep until stop
// - sleep outside stopped/sleep flags invalid
// - bus wake moves sleep to stopped, notice
// - wake-causing frame is discarded
// - wake during sleep transition fails stop
// - bus-off: started to stopped, notice on the same edge
// - bus-off cancels pending, leaves bus
// - no automatic bus-off recovery
// - deinit to uninitialised; error if started
// - uninitialised: reset config, no irq, off bus
// - stopped: no error frames, no acks
// - logical sleep leaves hardware stopped; a start request still starts it
`default_nettype none
module ccm_mode_fsm
  import ccm_pkg::*;
#(
  parameter int unsigned NUM_CTRL = CCM_NUM_CTRL,
  parameter int unsigned CFG_W = CCM_CFG_W,
  parameter bit HW_SLEEP = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [NUM_CTRL-1:0] sel_i,
  input wire ccm_cmd_t cmd_i,
  input wire logic [CFG_W-1:0] rate_cfg_i,
  input wire logic [NUM_CTRL-1:0] bus_off_i,
  input wire logic [NUM_CTRL-1:0] bus_wake_i,
  input wire logic [NUM_CTRL-1:0] rx_frame_i,
  output logic module_not_initialised_o,
  output logic transition_err_o,
  output logic rate_not_ok_o,
  output logic stop_not_ok_o,
  output logic [NUM_CTRL-1:0][3:0] state_o,
  output logic [NUM_CTRL-1:0] mode_done_o,
  output logic [NUM_CTRL-1:0] mode_change_notice_o,
  output logic [NUM_CTRL-1:0] bus_off_notice_o,
  output logic [NUM_CTRL-1:0] wake_check_notice_o,
  output logic [NUM_CTRL-1:0] bus_on_o,
  output logic [NUM_CTRL-1:0] ack_en_o,
  output logic [NUM_CTRL-1:0] irq_en_o,
  output logic [NUM_CTRL-1:0] tx_cancel_o,
  output logic [NUM_CTRL-1:0] hw_sleep_o,
  output logic [NUM_CTRL-1:0] logic_sleep_o,
  output logic [NUM_CTRL-1:0] rx_deliver_o,
  output logic [NUM_CTRL-1:0][CFG_W-1:0] cfg_o
);

  // reset and static config constants are only 8 bits wide
  if (NUM_CTRL < 1 || NUM_CTRL > 16 || CFG_W < 1 || CFG_W > 8) begin : g_bad_param
    $error("ccm_mode_fsm: unsupported parameter values");
  end

  localparam logic [3:0] SETTLE = 4'(CCM_SETTLE_CYC);

  logic ready_ff;
  logic [NUM_CTRL-1:0] is_uninit;
  logic [NUM_CTRL-1:0] is_started;

  wire any_started = |is_started;
  wire all_uninit = &is_uninit;
  wire go_init = cmd_i.init_all && !ready_ff && all_uninit;
  wire bad_init = cmd_i.init_all && !(!ready_ff && all_uninit);
  wire go_deinit = cmd_i.deinit && ready_ff && !any_started;
  wire bad_deinit = cmd_i.deinit && !(ready_ff && !any_started);

  logic [NUM_CTRL-1:0] bad_mode;
  logic [NUM_CTRL-1:0] bad_rate;
  logic [NUM_CTRL-1:0] bad_stop;

  wire nxt_err = bad_init | bad_deinit | (|bad_mode);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_ff <= 1'b0;
      module_not_initialised_o <= 1'b1;
      transition_err_o <= 1'b0;
      rate_not_ok_o <= 1'b0;
      stop_not_ok_o <= 1'b0;
    end else if (clk_en_i) begin
      if (go_init) begin
        ready_ff <= 1'b1;
      end else if (go_deinit) begin
        ready_ff <= 1'b0;
      end
      module_not_initialised_o <= go_init ? 1'b0 : (go_deinit ? 1'b1 : !ready_ff);
      transition_err_o <= nxt_err;
      rate_not_ok_o <= |bad_rate;
      stop_not_ok_o <= |bad_stop;
    end
  end

  for (genvar c = 0; c < NUM_CTRL; c++) begin : g_ctrl
    ccm_state_t state_ff;
    ccm_state_t nxt_state;
    logic [3:0] cnt_ff;
    logic [CFG_W-1:0] cfg_ff;
    logic lsleep_ff;
    logic wake_ff;
    logic sel;
    logic start_rq;
    logic stop_rq;
    logic sleep_rq;
    logic rate_rq;
    logic changes;

    assign sel = sel_i[c];
    assign start_rq = sel && cmd_i.mode_req && cmd_i.mode == CCM_REQ_START;
    assign stop_rq = sel && cmd_i.mode_req && cmd_i.mode == CCM_REQ_STOP;
    assign sleep_rq = sel && cmd_i.mode_req && cmd_i.mode == CCM_REQ_SLEEP;
    assign rate_rq = sel && cmd_i.rate_req;
    assign is_uninit[c] = state_ff == CCM_ST_UNINIT;
    assign is_started[c] = state_ff == CCM_ST_STARTED;

    assign bad_mode[c] = (start_rq && state_ff != CCM_ST_STOPPED) ||
      (sleep_rq && state_ff != CCM_ST_STOPPED && state_ff != CCM_ST_SLEEP) ||
      (stop_rq && (state_ff == CCM_ST_UNINIT));
    assign bad_rate[c] = rate_rq && cmd_i.rate_reinit && state_ff != CCM_ST_STOPPED;
    // wake during a pending sleep entry makes the following stop fail
    assign bad_stop[c] = stop_rq && wake_ff;

    always_comb begin
      nxt_state = state_ff;
      case (state_ff)
        CCM_ST_UNINIT: begin
          if (go_init) nxt_state = CCM_ST_STOPPED;
        end
        CCM_ST_STOPPED: begin
          if (go_deinit) nxt_state = CCM_ST_UNINIT;
          else if (start_rq) nxt_state = CCM_ST_STARTED;
          else if (sleep_rq && HW_SLEEP) nxt_state = CCM_ST_SLEEP;
        end
        CCM_ST_STARTED: begin
          // no automatic recovery: only an explicit start returns to the bus
          if (bus_off_i[c]) nxt_state = CCM_ST_STOPPED;
          else if (stop_rq) nxt_state = CCM_ST_STOPPED;
        end
        CCM_ST_SLEEP: begin
          if (go_deinit) nxt_state = CCM_ST_UNINIT;
          else if (bus_wake_i[c]) nxt_state = CCM_ST_STOPPED;
          else if (stop_rq) nxt_state = CCM_ST_STOPPED;
        end
        default: nxt_state = CCM_ST_UNINIT;
      endcase
    end

    // rate change or logical sleep entry also needs settle time
    assign changes = (nxt_state != state_ff) || (rate_rq && !bad_rate[c]) ||
      (!HW_SLEEP && sleep_rq && state_ff == CCM_ST_STOPPED);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        state_ff <= CCM_ST_UNINIT;
        cnt_ff <= CCM_CNT_ZERO;
        cfg_ff <= CFG_W'(CCM_CFG_RESET);
        lsleep_ff <= 1'b0;
        wake_ff <= 1'b0;
        mode_done_o[c] <= 1'b1;
        mode_change_notice_o[c] <= 1'b0;
        bus_off_notice_o[c] <= 1'b0;
        wake_check_notice_o[c] <= 1'b0;
        tx_cancel_o[c] <= 1'b0;
        rx_deliver_o[c] <= 1'b0;
      end else if (clk_en_i) begin
        state_ff <= nxt_state;
        // busy while the hardware settles, done flag polled by host
        if (changes) begin
          cnt_ff <= SETTLE;
          mode_done_o[c] <= 1'b0;
        end else if (cnt_ff != CCM_CNT_ZERO) begin
          cnt_ff <= cnt_ff - 4'h1;
          mode_done_o[c] <= cnt_ff == 4'h1;
        end
        // notice pulses once the settled mode is reached
        mode_change_notice_o[c] <= cnt_ff == 4'h1 && !changes;
        if (nxt_state == CCM_ST_UNINIT) begin
          cfg_ff <= CFG_W'(CCM_CFG_RESET);
        end else if (go_init) begin
          cfg_ff <= CFG_W'(CCM_CFG_STATIC);
        end else if (rate_rq && !bad_rate[c]) begin
          cfg_ff <= rate_cfg_i;
        end
        if (stop_rq || nxt_state == CCM_ST_UNINIT) begin
          lsleep_ff <= 1'b0;
        end else if (!HW_SLEEP && sleep_rq && state_ff == CCM_ST_STOPPED) begin
          lsleep_ff <= 1'b1;
        end
        if (bus_wake_i[c] && HW_SLEEP && (state_ff == CCM_ST_SLEEP || cnt_ff != CCM_CNT_ZERO)) begin
          wake_ff <= 1'b1;
        end else if (stop_rq || start_rq) begin
          wake_ff <= 1'b0;
        end
        wake_check_notice_o[c] <= HW_SLEEP && state_ff == CCM_ST_SLEEP && bus_wake_i[c];
        // notice raised on the same edge that stopped is entered
        bus_off_notice_o[c] <= is_started[c] && bus_off_i[c];
        tx_cancel_o[c] <= (stop_rq && state_ff != CCM_ST_UNINIT) ||
          (is_started[c] && bus_off_i[c]);
        // wake frame dropped; only a started controller delivers frames
        rx_deliver_o[c] <= rx_frame_i[c] && is_started[c] && !bus_wake_i[c];
      end
    end

    assign state_o[c] = state_ff;
    assign cfg_o[c] = cfg_ff;
    assign bus_on_o[c] = is_started[c];
    assign ack_en_o[c] = is_started[c];
    assign irq_en_o[c] = !is_uninit[c];
    assign hw_sleep_o[c] = state_ff == CCM_ST_SLEEP;
    assign logic_sleep_o[c] = lsleep_ff || state_ff == CCM_ST_SLEEP;
  end

endmodule // ccm_mode_fsm
`default_nettype wire

/* File: test/ccm_mode_fsm_sva.sv */
// checker: concurrent assertions on the mode state machine ports
`default_nettype none
module ccm_mode_fsm_sva
  import ccm_pkg::*;
#(
  parameter int unsigned NUM_CTRL = 2,
  parameter int unsigned CFG_W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [NUM_CTRL-1:0] sel_i,
  input wire ccm_cmd_t cmd_i,
  input wire logic [NUM_CTRL-1:0] bus_off_i,
  input wire logic [NUM_CTRL-1:0] bus_wake_i,
  input wire logic module_not_initialised_o,
  input wire logic transition_err_o,
  input wire logic [NUM_CTRL-1:0][3:0] state_o,
  input wire logic [NUM_CTRL-1:0] mode_done_o,
  input wire logic [NUM_CTRL-1:0] bus_off_notice_o,
  input wire logic [NUM_CTRL-1:0] wake_check_notice_o,
  input wire logic [NUM_CTRL-1:0] bus_on_o,
  input wire logic [NUM_CTRL-1:0] ack_en_o,
  input wire logic [NUM_CTRL-1:0] irq_en_o,
  input wire logic [NUM_CTRL-1:0] tx_cancel_o,
  input wire logic [NUM_CTRL-1:0][CFG_W-1:0] cfg_o
);
  // only controller 0 is watched; the others share the same logic
  wire logic tk = clk_en_i && cmd_i.mode_req && sel_i[0];
  wire logic stp = state_o[0] == CCM_ST_STOPPED;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  init_stop_a: assert property (clk_en_i && cmd_i.init_all && module_not_initialised_o |=> stp)
    else $error("init did not stop controller");
  init_err_a: assert property (clk_en_i && cmd_i.init_all && !module_not_initialised_o |=> transition_err_o)
    else $error("second init not flagged");
  start_go_a: assert property (tk && cmd_i.mode == CCM_REQ_START && stp && !bus_off_i[0] |=> bus_on_o[0])
    else $error("start did not join bus");
  start_err_a: assert property (tk && cmd_i.mode == CCM_REQ_START && !stp |=> transition_err_o)
    else $error("bad start not flagged");
  stop_cancel_a: assert property (tk && cmd_i.mode == CCM_REQ_STOP && state_o[0] != CCM_ST_UNINIT
    |=> tx_cancel_o[0])
    else $error("stop did not cancel");
  bus_off_a: assert property (clk_en_i && bus_off_i[0] && state_o[0] == CCM_ST_STARTED |=> stp && bus_off_notice_o[0])
    else $error("bus-off not handled");
  stop_quiet_a: assert property (stp |-> !ack_en_o[0] && !bus_on_o[0])
    else $error("stopped controller on bus");
  uninit_off_a: assert property (state_o[0] == CCM_ST_UNINIT |-> !bus_on_o[0] && !irq_en_o[0] && cfg_o[0] == '0)
    else $error("uninit controller active");
  settle_hold_a: assert property ($fell(mode_done_o[0]) |-> !mode_done_o[0] [*8])
    else $error("mode change settled early");
  wake_stop_a: assert property (clk_en_i && bus_wake_i[0] && state_o[0] == CCM_ST_SLEEP |=> stp && wake_check_notice_o[0])
    else $error("bus wake not handled");
endmodule // ccm_mode_fsm_sva
bind ccm_mode_fsm ccm_mode_fsm_sva #(.NUM_CTRL(NUM_CTRL), .CFG_W(CFG_W)) i_ccm_mode_fsm_sva (.*);
`default_nettype wire

/* File: test/ccm_bus_model.sv */
// model: bus side events seen by the mode state machine
`default_nettype none
module ccm_bus_model #(
  parameter int unsigned N = 2
) (
  input wire logic core_clk_i,
  output logic [N-1:0] bus_off_o,
  output logic [N-1:0] bus_wake_o,
  output logic [N-1:0] rx_frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_off_o = '0;
    bus_wake_o = '0;
    rx_frame_o = '0;
  end
  // k: bit0 bus-off, bit1 wake carried by a frame, bit2 plain frame
  task automatic ev(input logic [2:0] k, input logic [N-1:0] m);
    bus_off_o = k[0] ? m : '0;
    bus_wake_o = k[1] ? m : '0;
    rx_frame_o = (k[1] | k[2]) ? m : '0;
    @(posedge core_clk_i);
    #1;
    bus_off_o = '0;
    bus_wake_o = '0;
    rx_frame_o = '0;
  endtask
endmodule // ccm_bus_model
`default_nettype wire

/* File: test/tb.sv */
// testbench: random and corner mode sequences for the state machine
`default_nettype none
module tb;
  import ccm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic clk_en_i = 1;
  logic [1:0] sel_i = '0;
  ccm_cmd_t cmd_i = '0;
  logic [7:0] rate_cfg_i = '0;
  logic [1:0] bus_off_i, bus_wake_i, rx_frame_i, mode_done_o, mode_change_notice_o;
  logic module_not_initialised_o, transition_err_o, rate_not_ok_o, stop_not_ok_o;
  logic [1:0][3:0] state_o;
  logic [1:0][7:0] cfg_o;
  logic [1:0] bus_off_notice_o, wake_check_notice_o, bus_on_o, ack_en_o, irq_en_o;
  logic [1:0] tx_cancel_o, hw_sleep_o, logic_sleep_o, rx_deliver_o;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  ccm_state_t es [2] = '{CCM_ST_UNINIT, CCM_ST_UNINIT};
  logic [7:0] ec [2] = '{CCM_CFG_RESET, CCM_CFG_RESET};
  ccm_mode_fsm #(.NUM_CTRL(2), .CFG_W(8), .HW_SLEEP(1'b1)) i_ccm_mode_fsm (.*);
  ccm_bus_model i_ccm_bus_model (.core_clk_i, .bus_off_o(bus_off_i), .bus_wake_o(bus_wake_i),
    .rx_frame_o(rx_frame_i));
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a hang costs at most a few thousand cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk_b(string n, logic e, logic s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic chk_v(string n, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic ccm_state_t nxt(ccm_state_t s, ccm_mode_t m);
    if (s == CCM_ST_UNINIT) return s;
    if (m == CCM_REQ_STOP) return CCM_ST_STOPPED;
    if (m == CCM_REQ_START) return s == CCM_ST_STOPPED ? CCM_ST_STARTED : s;
    return s == CCM_ST_STARTED ? s : CCM_ST_SLEEP;
  endfunction
  // one-cycle command pulse; settings stay put after it
  task automatic go(ccm_cmd_t c, logic [1:0] s);
    // one idle edge first so cmd_i is never cleared and reloaded in one step
    @(posedge core_clk_i);
    #1;
    cmd_i = c;
    sel_i = s;
    rate_cfg_i = 8'($urandom);
    @(posedge core_clk_i);
    #1;
    cmd_i = '0;
  endtask
  task automatic mode(ccm_mode_t m, int i);
    ccm_cmd_t c;
    logic er;
    c = '0;
    c.mode_req = 1'b1;
    c.mode = m;
    er = es[i] == CCM_ST_UNINIT || (m == CCM_REQ_START && es[i] != CCM_ST_STOPPED);
    er = er || (m == CCM_REQ_SLEEP && es[i] == CCM_ST_STARTED);
    es[i] = nxt(es[i], m);
    go(c, 2'h1 << i);
    chk_v("state", es[i], state_o[i]);
    chk_b("trans err", er, transition_err_o);
    chk_b("tx cancel", m == CCM_REQ_STOP, tx_cancel_o[i]);
  endtask
  task automatic rate(int i, logic ri);
    ccm_cmd_t c;
    logic ok;
    c = '0;
    c.rate_req = 1'b1;
    c.rate_reinit = ri;
    ok = !ri || es[i] == CCM_ST_STOPPED;
    go(c, 2'h1 << i);
    if (ok) ec[i] = rate_cfg_i;
    chk_v("cfg", ec[i], cfg_o[i]);
    chk_v("state", es[i], state_o[i]);
    chk_b("rate nok", !ok, rate_not_ok_o);
  endtask
  initial begin
    ccm_cmd_t c;
    void'($urandom(38));
    repeat (4) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    chk_b("not init", 1'b1, module_not_initialised_o);
    chk_v("cfg", CCM_CFG_RESET, cfg_o[1]);
    mode(CCM_REQ_START, 0);
    c = '0;
    c.init_all = 1'b1;
    go(c, 2'h0);
    for (int i = 0; i < 2; i++) begin
      es[i] = CCM_ST_STOPPED;
      ec[i] = CCM_CFG_STATIC;
      chk_v("state", es[i], state_o[i]);
      chk_v("cfg", ec[i], cfg_o[i]);
    end
    repeat (10) @(posedge core_clk_i);
    #1 chk_b("done", 1'b1, mode_done_o[1]);
    chk_b("mode notice", 1'b1, mode_change_notice_o[1]);
    go(c, 2'h0);
    chk_b("init err", 1'b1, transition_err_o);
    repeat (80) begin
      if ($urandom % 4 == 0) rate($urandom % 2, 1'($urandom));
      else mode(ccm_mode_t'($urandom % 3), $urandom % 2);
    end
    mode(CCM_REQ_STOP, 0);
    mode(CCM_REQ_START, 0);
    i_ccm_bus_model.ev(3'h1, 2'h1);
    es[0] = CCM_ST_STOPPED;
    chk_b("bus off notice", 1'b1, bus_off_notice_o[0]);
    chk_b("tx cancel", 1'b1, tx_cancel_o[0]);
    repeat (20) @(posedge core_clk_i);
    #1 chk_v("state", es[0], state_o[0]);
    mode(CCM_REQ_STOP, 1);
    mode(CCM_REQ_SLEEP, 1);
    chk_b("hw sleep", 1'b1, hw_sleep_o[1]);
    chk_b("logic sleep", 1'b1, logic_sleep_o[1]);
    // host polls the done flag with a bounded wait
    repeat (20) begin
      @(posedge core_clk_i);
      #1;
      if (mode_done_o[1] === 1'b1) break;
    end
    i_ccm_bus_model.ev(3'h2, 2'h2);
    es[1] = CCM_ST_STOPPED;
    chk_v("state", es[1], state_o[1]);
    chk_b("wake notice", 1'b1, wake_check_notice_o[1]);
    chk_b("rx deliver", 1'b0, rx_deliver_o[1]);
    mode(CCM_REQ_START, 1);
    i_ccm_bus_model.ev(3'h4, 2'h2);
    chk_b("rx deliver", 1'b1, rx_deliver_o[1]);
    mode(CCM_REQ_STOP, 1);
    mode(CCM_REQ_SLEEP, 1);
    i_ccm_bus_model.ev(3'h2, 2'h2);
    es[1] = CCM_ST_STOPPED;
    mode(CCM_REQ_STOP, 1);
    chk_b("stop nok", 1'b1, stop_not_ok_o);
    mode(CCM_REQ_START, 0);
    c = '0;
    c.deinit = 1'b1;
    go(c, 2'h0);
    chk_b("deinit err", 1'b1, transition_err_o);
    mode(CCM_REQ_STOP, 0);
    go(c, 2'h0);
    chk_v("state", CCM_ST_UNINIT, state_o[0]);
    chk_v("state", CCM_ST_UNINIT, state_o[1]);
    chk_b("not init", 1'b1, module_not_initialised_o);
    summarize();
  end
endmodule // tb
`default_nettype wire
